// file: rtl/lrcr_regs.v
// Purpose: control registers for regulators seven (tail fields), eight and nine
// Assumes: AXI4-Lite slave, 32-bit data; pins asynchronous; sequencer on aclk
// Notes: registers sit at index*4; reg seven holds only bits 2:0 here
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`include "lrcr_map.vh"
module lrcr_regs (
  input wire aclk,
  input wire aresetn,
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [9:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire general_pin_one,
  input wire general_pin_two,
  input wire general_pin_thirteen,
  input wire seq_apply,
  input wire seq_to_active,
  output wire reg_seven_on,
  output wire reg_eight_on,
  output wire reg_nine_on,
  output wire reg_eight_volt_choice,
  output wire reg_nine_volt_choice,
  output wire reg_seven_pulldown_en,
  output wire reg_eight_pulldown_en,
  output wire reg_nine_pulldown_en
);
  reg [7:0] ctl_seven_r;
  reg [7:0] ctl_eight_r;
  reg [7:0] ctl_nine_r;
  reg [7:0] ctl_seven_nxt;
  reg [7:0] ctl_eight_nxt;
  reg [7:0] ctl_nine_nxt;
  reg [9:0] aw_addr_r;
  reg aw_held_r;
  reg [31:0] w_data_r;
  reg w_strb0_r;
  reg w_held_r;
  reg [2:0] pin_evt_r;
  wire [2:0] pin_level;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;
  wire seven_en_up;
  wire seven_en_dn;
  wire eight_en_up;
  wire eight_en_dn;
  wire eight_v_up;
  wire eight_v_dn;
  wire nine_en_up;
  wire nine_en_dn;
  wire nine_v_up;
  wire nine_v_dn;
  wire wr_fire;
  wire [7:0] wr_idx;
  wire [7:0] rd_idx;
  wire [7:0] wbyte;
  wire wr_hit_seven;
  wire wr_hit_eight;
  wire wr_hit_nine;
  wire wr_hit_any;
  wire wr_store;
  reg [31:0] rd_word;
  reg rd_bad;

  lrcr_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins_in({general_pin_thirteen, general_pin_two, general_pin_one}),
    .pins_level(pin_level),
    .pins_rise(pin_rise),
    .pins_fall(pin_fall)
  );

  lrcr_pin_pick u_pick_seven_en (
    .sel(ctl_seven_r[`LRCR_FLD_EPIN_HI:`LRCR_FLD_EPIN_LO]),
    .rise(pin_rise),
    .fall(pin_fall),
    .pin_up(seven_en_up),
    .pin_down(seven_en_dn)
  );

  lrcr_pin_pick u_pick_eight_en (
    .sel(ctl_eight_r[`LRCR_FLD_EPIN_HI:`LRCR_FLD_EPIN_LO]),
    .rise(pin_rise),
    .fall(pin_fall),
    .pin_up(eight_en_up),
    .pin_down(eight_en_dn)
  );

  lrcr_pin_pick u_pick_eight_v (
    .sel(ctl_eight_r[`LRCR_FLD_VPIN_HI:`LRCR_FLD_VPIN_LO]),
    .rise(pin_rise),
    .fall(pin_fall),
    .pin_up(eight_v_up),
    .pin_down(eight_v_dn)
  );

  lrcr_pin_pick u_pick_nine_en (
    .sel(ctl_nine_r[`LRCR_FLD_EPIN_HI:`LRCR_FLD_EPIN_LO]),
    .rise(pin_rise),
    .fall(pin_fall),
    .pin_up(nine_en_up),
    .pin_down(nine_en_dn)
  );

  lrcr_pin_pick u_pick_nine_v (
    .sel(ctl_nine_r[`LRCR_FLD_VPIN_HI:`LRCR_FLD_VPIN_LO]),
    .rise(pin_rise),
    .fall(pin_fall),
    .pin_up(nine_v_up),
    .pin_down(nine_v_dn)
  );

  // write channel: address and data accepted independently, held until both
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_idx = aw_addr_r[9:2];
  assign wbyte = w_data_r[7:0];
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = s_axi_araddr[9:2];
  // unmapped indices answer with an error and store nothing
  assign wr_hit_seven = (wr_idx == `LRCR_IDX_SEVEN);
  assign wr_hit_eight = (wr_idx == `LRCR_IDX_EIGHT);
  assign wr_hit_nine = (wr_idx == `LRCR_IDX_NINE);
  assign wr_hit_any = wr_hit_seven || wr_hit_eight || wr_hit_nine;
  // a cleared low strobe keeps the byte but still answers okay
  assign wr_store = wr_fire && w_strb0_r;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 10'h000;
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LRCR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_hit_any)
          s_axi_bresp <= `LRCR_RESP_OKAY;
        else
          s_axi_bresp <= `LRCR_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // software write first, then pin and sequencer events override the same cycle
  always @*
  begin
    ctl_seven_nxt = ctl_seven_r;
    ctl_eight_nxt = ctl_eight_r;
    ctl_nine_nxt = ctl_nine_r;
    if (wr_store)
    begin
      if (wr_hit_seven)
        ctl_seven_nxt = {5'h00, wbyte[2:0]};
      if (wr_hit_eight)
        ctl_eight_nxt = wbyte;
      if (wr_hit_nine)
        ctl_nine_nxt = wbyte;
    end
    if (seven_en_up)
      ctl_seven_nxt[`LRCR_BIT_ON] = 1'b1;
    else if (seven_en_dn)
      ctl_seven_nxt[`LRCR_BIT_ON] = 1'b0;
    if (eight_en_up)
      ctl_eight_nxt[`LRCR_BIT_ON] = 1'b1;
    else if (eight_en_dn)
      ctl_eight_nxt[`LRCR_BIT_ON] = 1'b0;
    if (eight_v_up)
      ctl_eight_nxt[`LRCR_BIT_VSEL] = 1'b0;
    else if (eight_v_dn)
      ctl_eight_nxt[`LRCR_BIT_VSEL] = 1'b1;
    if (nine_en_up)
      ctl_nine_nxt[`LRCR_BIT_ON] = 1'b1;
    else if (nine_en_dn)
      ctl_nine_nxt[`LRCR_BIT_ON] = 1'b0;
    if (nine_v_up)
      ctl_nine_nxt[`LRCR_BIT_VSEL] = 1'b0;
    else if (nine_v_dn)
      ctl_nine_nxt[`LRCR_BIT_VSEL] = 1'b1;
    if (seq_apply)
    begin
      // sequencer only where field is 00
      if (ctl_eight_r[`LRCR_FLD_EPIN_HI:`LRCR_FLD_EPIN_LO] == `LRCR_PIN_NONE)
        ctl_eight_nxt[`LRCR_BIT_ON] = ctl_eight_r[`LRCR_BIT_SEQ_TGT];
      if (ctl_nine_r[`LRCR_FLD_EPIN_HI:`LRCR_FLD_EPIN_LO] == `LRCR_PIN_NONE)
        ctl_nine_nxt[`LRCR_BIT_ON] = ctl_nine_r[`LRCR_BIT_SEQ_TGT];
      if (ctl_eight_r[`LRCR_FLD_VPIN_HI:`LRCR_FLD_VPIN_LO] == `LRCR_PIN_NONE)
        ctl_eight_nxt[`LRCR_BIT_VSEL] = !seq_to_active;
      if (ctl_nine_r[`LRCR_FLD_VPIN_HI:`LRCR_FLD_VPIN_LO] == `LRCR_PIN_NONE)
        ctl_nine_nxt[`LRCR_BIT_VSEL] = !seq_to_active;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_seven_r <= `LRCR_CTRL_RESET;
      ctl_eight_r <= `LRCR_CTRL_RESET;
      ctl_nine_r <= `LRCR_CTRL_RESET;
      pin_evt_r <= 3'h0;
    end
    else
    begin
      ctl_seven_r <= ctl_seven_nxt;
      ctl_eight_r <= ctl_eight_nxt;
      ctl_nine_r <= ctl_nine_nxt;
      // sticky record of pin edges, cleared by reading status
      if (s_axi_arvalid && s_axi_arready && rd_idx == `LRCR_IDX_STATUS)
        pin_evt_r <= pin_rise | pin_fall;
      else
        pin_evt_r <= pin_evt_r | pin_rise | pin_fall;
    end
  end

  // read mux kept apart so the answer register only latches its result
  always @*
  begin
    rd_word = 32'h00000000;
    rd_bad = 1'b0;
    case (rd_idx)
      `LRCR_IDX_SEVEN: rd_word = {24'h000000, ctl_seven_r};
      `LRCR_IDX_EIGHT: rd_word = {24'h000000, ctl_eight_r};
      `LRCR_IDX_NINE: rd_word = {24'h000000, ctl_nine_r};
      `LRCR_IDX_STATUS: rd_word = {26'h0000000, pin_evt_r, pin_level};
      default:
      begin
        rd_word = 32'h00000000;
        rd_bad = 1'b1;
      end
    endcase
  end

  // read channel: one cycle answer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LRCR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_bad ? `LRCR_RESP_SLVERR : `LRCR_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  assign reg_seven_on = ctl_seven_r[`LRCR_BIT_ON];
  assign reg_eight_on = ctl_eight_r[`LRCR_BIT_ON];
  assign reg_nine_on = ctl_nine_r[`LRCR_BIT_ON];
  // voltage choice straight from the bit
  assign reg_eight_volt_choice = ctl_eight_r[`LRCR_BIT_VSEL];
  assign reg_nine_volt_choice = ctl_nine_r[`LRCR_BIT_VSEL];
  // pull-down only while disabled and not turned off
  assign reg_seven_pulldown_en = 1'b0;
  assign reg_eight_pulldown_en = !ctl_eight_r[`LRCR_BIT_PD_OFF] && !reg_eight_on;
  assign reg_nine_pulldown_en = !ctl_nine_r[`LRCR_BIT_PD_OFF] && !reg_nine_on;
endmodule // lrcr_regs

// file: shared/lrcr_map.vh
// Purpose: register offsets, field positions and reset values for the regulator control bank
// Assumes: AXI4-Lite 32-bit word per register, byte address = index * 4
// Notes: printed offsets are register indices, not byte addresses
`ifndef LRCR_MAP_VH
`define LRCR_MAP_VH
`define LRCR_IDX_SEVEN 8'h2c
`define LRCR_IDX_EIGHT 8'h2d
`define LRCR_IDX_NINE 8'h2e
`define LRCR_IDX_SEQ_CMD 8'h40
`define LRCR_IDX_STATUS 8'h41
`define LRCR_BIT_SEQ_TGT 7
`define LRCR_FLD_VPIN_HI 6
`define LRCR_FLD_VPIN_LO 5
`define LRCR_BIT_VSEL 4
`define LRCR_BIT_PD_OFF 3
`define LRCR_FLD_EPIN_HI 2
`define LRCR_FLD_EPIN_LO 1
`define LRCR_BIT_ON 0
`define LRCR_PIN_NONE 2'h0
`define LRCR_PIN_ONE 2'h1
`define LRCR_PIN_TWO 2'h2
`define LRCR_PIN_THIRTEEN 2'h3
`define LRCR_CTRL_RESET 8'h00
`define LRCR_RESP_OKAY 2'h0
`define LRCR_RESP_SLVERR 2'h2
`endif

// file: rtl/lrcr_pin_sync.v
// Purpose: two-flop synchroniser and edge detector for the three general pins
// Assumes: pins are asynchronous to aclk
// Notes: edge pulses last one cycle
`timescale 1ns/100ps
module lrcr_pin_sync (
  input wire aclk,
  input wire aresetn,
  input wire [2:0] pins_in,
  output wire [2:0] pins_level,
  output wire [2:0] pins_rise,
  output wire [2:0] pins_fall
);
  reg [2:0] meta_r;
  reg [2:0] sync_r;
  reg [2:0] prev_r;
  // only sync_r reads the first stage
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      prev_r <= 3'h0;
    end
    else
    begin
      meta_r <= pins_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign pins_level = sync_r;
  assign pins_rise = sync_r & ~prev_r;
  assign pins_fall = ~sync_r & prev_r;
endmodule // lrcr_pin_sync

// file: rtl/lrcr_pin_pick.v
// Purpose: decode a two-bit pin-control field into one pin's edges
// Assumes: edges come from lrcr_pin_sync
// Notes: field 00 yields no edges, leaving the sequencer in charge for eight and nine
`timescale 1ns/100ps
`include "lrcr_map.vh"
module lrcr_pin_pick (
  input wire [1:0] sel,
  input wire [2:0] rise,
  input wire [2:0] fall,
  output reg pin_up,
  output reg pin_down
);
  always @*
  begin
    pin_up = 1'b0;
    pin_down = 1'b0;
    case (sel)
      `LRCR_PIN_ONE:
      begin
        pin_up = rise[0];
        pin_down = fall[0];
      end
      `LRCR_PIN_TWO:
      begin
        pin_up = rise[1];
        pin_down = fall[1];
      end
      `LRCR_PIN_THIRTEEN:
      begin
        pin_up = rise[2];
        pin_down = fall[2];
      end
      default:
      begin
        pin_up = 1'b0;
        pin_down = 1'b0;
      end
    endcase
  end
endmodule // lrcr_pin_pick

// file: tb/lrcr_far.sv
// Purpose: far side model, general pins and sequencer
// Assumes: driven just after aclk edges
// Notes: pins are levels, high is the active state
`timescale 1ns/100ps
module lrcr_far (
  input wire aclk,
  output reg general_pin_one,
  output reg general_pin_two,
  output reg general_pin_thirteen,
  output reg seq_apply,
  output reg seq_to_active
);
  initial
  begin
    {general_pin_one, general_pin_two, general_pin_thirteen} = 3'h0;
    seq_apply = 1'b0;
    seq_to_active = 1'b0;
  end
  // wait covers sync and edge stage
  task pin(input integer p, input v);
  begin
    @(posedge aclk);
    if (p == 0)
      general_pin_one <= v;
    else if (p == 1)
      general_pin_two <= v;
    else
      general_pin_thirteen <= v;
    repeat (5) @(posedge aclk);
  end
  endtask
  task seq(input v);
  begin
    @(posedge aclk);
    seq_apply <= 1'b1;
    seq_to_active <= v;
    @(posedge aclk);
    seq_apply <= 1'b0;
    @(posedge aclk);
  end
  endtask
endmodule // lrcr_far

// file: tb/lrcr_chk.sv
// Purpose: port checks of the control bank
// Assumes: one clock, sync low reset
// Notes: bound to lrcr_regs
`timescale 1ns/100ps
module lrcr_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire general_pin_one,
  input wire general_pin_two,
  input wire general_pin_thirteen,
  input wire seq_apply,
  input wire reg_seven_on,
  input wire reg_eight_on,
  input wire reg_nine_on,
  input wire reg_seven_pulldown_en,
  input wire reg_eight_pulldown_en,
  input wire reg_nine_pulldown_en
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read unanswered");
  a_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  a_wr_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_pd_eight: assert property (reg_eight_on |-> !reg_eight_pulldown_en)
    else $error("pull-down while on");
  a_pd_nine: assert property (reg_nine_on |-> !reg_nine_pulldown_en)
    else $error("pull-down while on");
  a_pd_seven: assert property (!reg_seven_pulldown_en)
    else $error("seven pull-down driven");
  a_quiet_hold: assert property ((!s_axi_awvalid && !s_axi_wvalid && !seq_apply &&
    $stable({general_pin_one, general_pin_two, general_pin_thirteen}))[*4]
    |=> $stable({reg_seven_on, reg_eight_on, reg_nine_on}))
    else $error("enable moved without cause");
endmodule // lrcr_chk

// file: tb/tb_top.sv
// Purpose: self-checking bench of the control bank
// Assumes: model updated beside every action
// Notes: seven keeps bits 2:0 only
`timescale 1ns/100ps
module tb_top;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [9:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rd;
  reg [3:0] s_axi_wstrb;
  reg [1:0] rs;
  reg [7:0] m [0:2];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire general_pin_one, general_pin_two, general_pin_thirteen, seq_apply, seq_to_active;
  wire reg_seven_on, reg_eight_on, reg_nine_on, reg_eight_volt_choice, reg_nine_volt_choice;
  wire reg_seven_pulldown_en, reg_eight_pulldown_en, reg_nine_pulldown_en;
  wire [7:0] o = {reg_nine_pulldown_en, reg_eight_pulldown_en, reg_seven_pulldown_en,
    reg_nine_volt_choice, reg_eight_volt_choice, reg_nine_on, reg_eight_on, reg_seven_on};
  integer mismatches, n_checks, seed, k, p;
  lrcr_regs dut_u (.*);
  lrcr_far far_u (.*);
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input [63:0] nm, input [31:0] s, input [31:0] e);
  begin
    n_checks = n_checks + 1;
    if (s !== e)
    begin
      mismatches = mismatches + 1;
      $display("ERROR %0s exp %h seen %h", nm, e, s);
    end
  end
  endtask
  task wr(input [9:0] a, input [31:0] d, input [3:0] s);
    integer t;
  begin
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (t = 0; t < 20 && !s_axi_bvalid; t = t + 1)
    begin
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("bwait", t < 20, 1);
    if (t >= 20)
      end_sim;
  end
  endtask
  task rdx(input [9:0] a);
    integer t;
  begin
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (t = 0; t < 20 && !s_axi_rvalid; t = t + 1)
    begin
      @(posedge aclk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("rwait", t < 20, 1);
    if (t >= 20)
      end_sim;
  end
  endtask
  task wreg(input integer i, input [31:0] d);
  begin
    wr(10'hb0 + 4 * i, d, 4'hf);
    // seven keeps only its tail bits
    m[i] = d[7:0] & (i == 0 ? 8'h07 : 8'hff);
    chk("wresp", rs, 2'h0);
  end
  endtask
  task rreg(input integer i);
  begin
    rdx(10'hb0 + 4 * i);
    chk("rdata", rd, m[i]);
    chk("rresp", rs, 2'h0);
  end
  endtask
  task outs;
  begin
    #1;
    chk("outs", o, {!m[2][3] && !m[2][0], !m[1][3] && !m[1][0], 1'b0, m[2][4], m[1][4], m[2][0], m[1][0], m[0][0]});
  end
  endtask
  task mpin(input integer q, input v);
    integer j;
  begin
    for (j = 0; j < 3; j = j + 1)
    begin
      if (m[j][2:1] == q + 1)
        m[j][0] = v;
      if (j > 0 && m[j][6:5] == q + 1)
        m[j][4] = !v;
    end
  end
  endtask
  task stat(input integer q, input v);
  begin
    // one edge since the last read, so exactly one sticky bit
    rdx(10'h104);
    chk("stlvl", rd[2:0], {31'h0, v} << q);
    chk("stedge", rd[31:3], 32'h1 << q);
    chk("stresp", rs, 2'h0);
  end
  endtask
  task mseq(input v);
    integer j;
  begin
    for (j = 1; j < 3; j = j + 1)
    begin
      if (m[j][2:1] == 0)
        m[j][0] = m[j][7];
      if (m[j][6:5] == 0)
        m[j][4] = !v;
    end
  end
  endtask
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 56'h0;
    {mismatches, n_checks, seed} = {32'd0, 32'd0, 32'd4};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 3; k = k + 1)
    begin
      m[k] = 8'h00;
      rreg(k);
    end
    outs;
    for (k = 0; k < 9; k = k + 1)
    begin
      wreg(k % 3, $random(seed));
      rreg(k % 3);
      outs;
    end
    $display("test registers done");
    wr(10'h100, 32'h0, 4'hf);
    chk("wslverr", rs, 2'h2);
    rdx(10'h100);
    chk("rslverr", rs, 2'h2);
    chk("rzero", rd, 0);
    wr(10'hb4, 32'hff, 4'h0);
    chk("nostrb", rs, 2'h0);
    rreg(1);
    $display("test refusals done");
    for (k = 1; k < 4; k = k + 1)
    begin
      wreg(0, k * 2);
      wreg(1, k * 34 + 16);
      wreg(2, k * 34 + 8);
      for (p = 0; p < 3; p = p + 1)
      begin
        far_u.pin(p, 1'b1);
        mpin(p, 1'b1);
        outs;
        stat(p, 1'b1);
        far_u.pin(p, 1'b0);
        mpin(p, 1'b0);
        outs;
        stat(p, 1'b0);
      end
    end
    $display("test pins done");
    wreg(0, 8'h02);
    for (k = 0; k < 6; k = k + 1)
    begin
      wreg(1, $random(seed) & (k[0] ? 8'hff : 8'h99));
      wreg(2, $random(seed) & 8'h99);
      far_u.seq(k[1]);
      mseq(k[1]);
      outs;
    end
    $display("test sequencer done");
    end_sim;
  end
endmodule // tb_top
bind lrcr_regs lrcr_chk chk_u (.*);
